/* File: fsg_pkg.sv */
// Package for the host-side flash lock and OTP security controller
package fsg_pkg;
  localparam int             ADDR_W        = 24;
  localparam int             DATA_W        = 16;
  // Command codes written on the data bus
  localparam logic [15:0]    CODE_LOCK_SETUP   = 16'h0060;
  localparam logic [15:0]    CODE_LOCK_SET     = 16'h0001;
  localparam logic [15:0]    CODE_LOCK_CLEAR   = 16'h00D0;
  localparam logic [15:0]    CODE_OTP_SETUP    = 16'h00C0;
  localparam logic [15:0]    CODE_ID_READ      = 16'h0090;
  localparam logic [15:0]    CODE_ARRAY_READ   = 16'h00FF;
  localparam logic [15:0]    CODE_CLEAR_STATUS = 16'h0050;
  localparam logic [15:0]    OTP_LOCK_VALUE    = 16'hFFFD;
  // Status bit positions
  localparam int             SM_READY_BIT       = 7;
  localparam int             ERASE_ERROR_BIT    = 5;
  localparam int             PROGRAM_ERROR_BIT  = 4;
  localparam int             DEVICE_PROTECT_BIT = 1;
  // Address layout
  localparam int             BLOCK_BITS     = 17;
  localparam logic [8:0]     LOCK_STATE_OFS = 9'h002;
  localparam logic [7:0]     OTP_WORD_FIRST = 8'h80;
  localparam logic [7:0]     OTP_WORD_LAST  = 8'h88;
  localparam logic [8:0]     OTP_BYTE_FIRST = 9'h100;
  localparam logic [8:0]     OTP_BYTE_LAST  = 9'h111;
  localparam logic [8:0]     OTP_LOCK_ADDR  = 9'h100;
  // Bus timing at 100 ns per clock
  localparam int             CLK_NS       = 100;
  localparam int             ACCESS_NS    = 100;
  localparam logic [3:0]     ACC_CYC      = 4'((ACCESS_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    OP_LOCK_BLOCK = 3'h0,
    OP_UNLOCK_ALL = 3'h1,
    OP_READ_LOCK  = 3'h2,
    OP_OTP_READ   = 3'h3,
    OP_OTP_PROG   = 3'h4,
    OP_OTP_LOCK   = 3'h5,
    OP_CLR_STATUS = 3'h6
  } fsg_op_type;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_SETUP = 8'h02,
    ST_CONF  = 8'h04,
    ST_POLL  = 8'h08,
    ST_CLEAR = 8'h10,
    ST_DATA  = 8'h20,
    ST_EXIT  = 8'h40,
    ST_RESP  = 8'h80
  } fsg_state_type;

  typedef struct packed {
    logic              ceN;
    logic              weN;
    logic              oeN;
    logic              dqOe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dqOut;
  } fsg_pins_type;

  typedef struct packed {
    logic badAddr;
    logic programError;
    logic eraseError;
    logic deviceProtect;
  } fsg_err_type;
endpackage

/* File: fsg_host.sv */
// Host controller issuing block lock and OTP command sequences to the flash
// Overview of operation
// - Lock block: write 0060h then 0001h, both at an address in the block.
// - Unlock all: write 0060h then 00D0h at any device address.
// - Check program error after lock, erase error after unlock; clear-status on error.
// - After identifier command, block base plus 02h shows lock on bit zero.
// - OTP readable in identification mode: enter 0090h, leave 00FFh.
// - OTP program: write 00C0h, next write carries address and data.
// - Lock user OTP by programming FFFDh to lock word 80h.
// - Word mode: A0 ignored, upper lines zero, words 80h to 88h.
// - Byte mode: A0 used, bytes 100h to 111h.
`timescale 1ns/100ps
`default_nettype none
module fsg_host (
  input  wire logic                          sys_clk,      // System clock
  input  wire logic                          rst,          // Synchronous reset
  input  wire logic                          clkEn,        // Freezes all state when low
  input  wire logic                          byteMode,     // Flash in byte-wide config
  input  wire logic                          cmdValid,     // Command request
  output logic                               cmdReady,     // Command accepted
  input  wire fsg_pkg::fsg_op_type           cmdOp,        // Operation
  input  wire logic [fsg_pkg::ADDR_W-1:0]    cmdAddr,      // Target address
  input  wire logic [fsg_pkg::DATA_W-1:0]    cmdData,      // OTP program data
  output logic                               rspValid,     // Result pulse
  output logic [fsg_pkg::DATA_W-1:0]         rspData,      // Read data or final status
  output fsg_pkg::fsg_err_type               rspErr,       // Error summary
  output fsg_pkg::fsg_pins_type              flashPins,    // Flash bus outputs
  input  wire logic [fsg_pkg::DATA_W-1:0]    dqIn,         // Flash data input
  input  wire logic                          readyStatusPin, // Ready/busy pin
  output logic                               progEnable    // Raises program-enable supply
);
  fsg_pkg::fsg_state_type            state,   next_state;
  logic [3:0]                        cnt,     next_cnt;
  fsg_pkg::fsg_op_type               op,      next_op;
  logic [fsg_pkg::ADDR_W-1:0]        addr,    next_addr;
  logic [fsg_pkg::DATA_W-1:0]        data,    next_data;
  logic [fsg_pkg::DATA_W-1:0]        rdData,  next_rdData;
  fsg_pkg::fsg_err_type              err,     next_err;
  fsg_pkg::fsg_pins_type             next_pins;
  logic                              next_progEnable;
  logic                              accDone;
  logic                              sampleNow;
  logic                              isRead;
  logic                              otpBad;
  logic [fsg_pkg::ADDR_W-1:0]        lockAddr;

  assign cmdReady  = (state == fsg_pkg::ST_IDLE) && clkEn;
  assign rspValid  = (state == fsg_pkg::ST_RESP) && clkEn;
  assign rspData   = rdData;
  assign rspErr    = err;
  assign accDone   = (cnt == fsg_pkg::ACC_CYC + 4'h1);
  assign sampleNow = (cnt == fsg_pkg::ACC_CYC);
  assign isRead    = (state == fsg_pkg::ST_POLL) || (state == fsg_pkg::ST_DATA);

  // OTP address window differs by bus width; A0 is ignored in word mode
  always_comb begin
    otpBad = 1'b0;
    if (cmdOp == fsg_pkg::OP_OTP_READ || cmdOp == fsg_pkg::OP_OTP_PROG) begin
      if (cmdAddr[fsg_pkg::ADDR_W-1:9] != '0) begin
        otpBad = 1'b1;
      end else if (byteMode) begin
        otpBad = (cmdAddr[8:0] < fsg_pkg::OTP_BYTE_FIRST) ||
                 (cmdAddr[8:0] > fsg_pkg::OTP_BYTE_LAST);
      end else begin
        otpBad = (cmdAddr[8:1] < fsg_pkg::OTP_WORD_FIRST) ||
                 (cmdAddr[8:1] > fsg_pkg::OTP_WORD_LAST);
      end
    end
  end

  // Lock state sits at offset 02h of the block base: word offset in word mode, byte offset in byte mode
  always_comb begin
    lockAddr = {cmdAddr[fsg_pkg::ADDR_W-1:fsg_pkg::BLOCK_BITS],
                {fsg_pkg::BLOCK_BITS{1'b0}}};
    if (byteMode) begin
      lockAddr[8:0] = fsg_pkg::LOCK_STATE_OFS;
    end else begin
      lockAddr[9:1] = fsg_pkg::LOCK_STATE_OFS;
    end
  end

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_op         = op;
    next_addr       = addr;
    next_data       = data;
    next_rdData     = rdData;
    next_err        = err;
    next_progEnable = progEnable;
    next_pins       = '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, dqOe: 1'b1,
                        addr: addr, dqOut: data};
    case (state)
      fsg_pkg::ST_IDLE: begin
        next_cnt = 4'h0;
        if (cmdValid) begin
          next_op     = cmdOp;
          next_addr   = (cmdOp == fsg_pkg::OP_READ_LOCK) ? lockAddr : cmdAddr;
          next_data   = cmdData;
          next_err    = '0;
          next_rdData = '0;
          if (cmdOp == fsg_pkg::OP_OTP_LOCK) begin
            next_addr      = '0;
            next_addr[8:0] = fsg_pkg::OTP_LOCK_ADDR;
            next_data      = fsg_pkg::OTP_LOCK_VALUE;
          end
          if (otpBad) begin
            next_err.badAddr = 1'b1;
            next_state       = fsg_pkg::ST_RESP;
          end else begin
            // Supply stays raised for the whole sequence so lock bits can move
            next_progEnable = 1'b1;
            next_state      = fsg_pkg::ST_SETUP;
          end
        end
      end
      fsg_pkg::ST_RESP: begin
        next_progEnable = 1'b0;
        next_state      = fsg_pkg::ST_IDLE;
      end
      default: begin
        next_cnt       = cnt + 4'h1;
        next_pins.ceN  = !(cnt < fsg_pkg::ACC_CYC);
        next_pins.weN  = isRead || !(cnt < fsg_pkg::ACC_CYC);
        next_pins.oeN  = !isRead || !(cnt < fsg_pkg::ACC_CYC);
        next_pins.dqOe = isRead;
        case (state)
          fsg_pkg::ST_SETUP: begin
            case (op)
              fsg_pkg::OP_LOCK_BLOCK, fsg_pkg::OP_UNLOCK_ALL:
                next_pins.dqOut = fsg_pkg::CODE_LOCK_SETUP;
              fsg_pkg::OP_OTP_PROG, fsg_pkg::OP_OTP_LOCK:
                next_pins.dqOut = fsg_pkg::CODE_OTP_SETUP;
              fsg_pkg::OP_CLR_STATUS:
                next_pins.dqOut = fsg_pkg::CODE_CLEAR_STATUS;
              default:
                next_pins.dqOut = fsg_pkg::CODE_ID_READ;
            endcase
          end
          fsg_pkg::ST_CONF: begin
            case (op)
              fsg_pkg::OP_LOCK_BLOCK: next_pins.dqOut = fsg_pkg::CODE_LOCK_SET;
              fsg_pkg::OP_UNLOCK_ALL: next_pins.dqOut = fsg_pkg::CODE_LOCK_CLEAR;
              default:                next_pins.dqOut = data;
            endcase
          end
          fsg_pkg::ST_CLEAR: next_pins.dqOut = fsg_pkg::CODE_CLEAR_STATUS;
          fsg_pkg::ST_EXIT:  next_pins.dqOut = fsg_pkg::CODE_ARRAY_READ;
          default:           next_pins.dqOut = data;
        endcase
        if (sampleNow && isRead) begin
          next_rdData = dqIn;
        end
        if (accDone) begin
          next_cnt = 4'h0;
          case (state)
            fsg_pkg::ST_SETUP: begin
              if (op == fsg_pkg::OP_CLR_STATUS) begin
                next_state = fsg_pkg::ST_RESP;
              end else if (op == fsg_pkg::OP_READ_LOCK || op == fsg_pkg::OP_OTP_READ) begin
                next_state = fsg_pkg::ST_DATA;
              end else begin
                next_state = fsg_pkg::ST_CONF;
              end
            end
            fsg_pkg::ST_CONF: next_state = fsg_pkg::ST_POLL;
            fsg_pkg::ST_POLL: begin
              // Reads already return status after setup, so no 0070h is needed
              if (rdData[fsg_pkg::SM_READY_BIT] && readyStatusPin) begin
                next_err.programError  = (op != fsg_pkg::OP_UNLOCK_ALL) &&
                                         rdData[fsg_pkg::PROGRAM_ERROR_BIT];
                next_err.eraseError    = (op == fsg_pkg::OP_UNLOCK_ALL) &&
                                         rdData[fsg_pkg::ERASE_ERROR_BIT];
                next_err.deviceProtect = rdData[fsg_pkg::DEVICE_PROTECT_BIT];
                if (rdData[fsg_pkg::PROGRAM_ERROR_BIT] || rdData[fsg_pkg::ERASE_ERROR_BIT] ||
                    rdData[fsg_pkg::DEVICE_PROTECT_BIT]) begin
                  next_state = fsg_pkg::ST_CLEAR;
                end else begin
                  next_state = fsg_pkg::ST_EXIT;
                end
              end
            end
            fsg_pkg::ST_CLEAR: next_state = fsg_pkg::ST_EXIT;
            fsg_pkg::ST_DATA: begin
              if (op == fsg_pkg::OP_READ_LOCK) begin
                next_rdData = {15'h0000, rdData[0]};
              end
              next_state = fsg_pkg::ST_EXIT;
            end
            default: next_state = fsg_pkg::ST_RESP;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state      <= fsg_pkg::ST_IDLE;
      cnt        <= 4'h0;
      op         <= fsg_pkg::OP_LOCK_BLOCK;
      addr       <= '0;
      data       <= '0;
      rdData     <= '0;
      err        <= '0;
      progEnable <= 1'b0;
      flashPins  <= '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, dqOe: 1'b1, addr: '0, dqOut: '0};
    end else if (clkEn) begin
      state      <= next_state;
      cnt        <= next_cnt;
      op         <= next_op;
      addr       <= next_addr;
      data       <= next_data;
      rdData     <= next_rdData;
      err        <= next_err;
      progEnable <= next_progEnable;
      flashPins  <= next_pins;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // A setup write is the cycle in which the strobe drops with 0060h on the bus
  sequence s_setupWrite;
    $fell(flashPins.weN) && flashPins.dqOut == 16'h0060;
  endsequence

  a_lock_confirm_code: assert property (
    $rose(state == fsg_pkg::ST_CONF) && op == fsg_pkg::OP_LOCK_BLOCK
      |-> ##1 (!flashPins.weN && flashPins.dqOut == 16'h0001 && flashPins.addr == addr))
    else $error("lock confirm code wrong");
  a_unlock_confirm_code: assert property (
    $rose(state == fsg_pkg::ST_CONF) && op == fsg_pkg::OP_UNLOCK_ALL
      |-> ##1 (!flashPins.weN && flashPins.dqOut == 16'h00D0))
    else $error("unlock confirm code wrong");
  a_setup_precedes_conf: assert property (
    s_setupWrite and (clkEn && (op == fsg_pkg::OP_LOCK_BLOCK || op == fsg_pkg::OP_UNLOCK_ALL))
      |-> ##[1:6] $rose(state == fsg_pkg::ST_CONF))
    else $error("confirm did not follow lock setup");
  a_error_clear_sent: assert property (
    clkEn && state == fsg_pkg::ST_POLL && accDone && rdData[7] && readyStatusPin && rdData[4]
      |=> state == fsg_pkg::ST_CLEAR ##1 (flashPins.dqOut == 16'h0050 && !flashPins.weN))
    else $error("clear status not issued after error");
  a_lock_read_bit: assert property (
    clkEn && state == fsg_pkg::ST_DATA && accDone && op == fsg_pkg::OP_READ_LOCK
      |=> rdData[15:1] == 15'h0000 && rdData[0] == $past(rdData[0]))
    else $error("lock state not taken from bit zero");
  a_id_exit_write: assert property (
    clkEn && state == fsg_pkg::ST_DATA && accDone
      |=> state == fsg_pkg::ST_EXIT ##1 (flashPins.dqOut == 16'h00FF && !flashPins.weN))
    else $error("array read not restored after id read");
  a_otp_setup_code: assert property (
    $rose(state == fsg_pkg::ST_CONF) && op == fsg_pkg::OP_OTP_PROG
      |-> $past(flashPins.dqOut, 2) == 16'h00C0 && !$past(flashPins.weN, 2))
    else $error("otp setup code missing");
  a_otp_lock_word: assert property (
    $rose(state == fsg_pkg::ST_CONF) && op == fsg_pkg::OP_OTP_LOCK
      |-> ##1 (flashPins.dqOut == 16'hFFFD && flashPins.addr == 24'h000100))
    else $error("otp lock word write wrong");
  a_otp_bad_addr: assert property (
    cmdValid && cmdReady && otpBad |=> state == fsg_pkg::ST_RESP && rspErr.badAddr
      && flashPins.ceN)
    else $error("bad otp address not refused");
endmodule // fsg_host
`default_nettype wire

/* File: fsg_flash_model.sv */
// Behavioural flash device answering the lock and OTP command sequences
`timescale 1ns/100ps
`default_nettype none
module fsg_flash_model #(
  parameter logic [15:0] FACTORY_BASE = 16'h5A00  // Arbitrary factory number
) (
  input  wire logic                  sys_clk,       // Clock
  input  wire fsg_pkg::fsg_pins_type pins,          // Host bus
  input  wire logic                  progEnable,    // Program-enable supply
  input  wire logic [7:0]            busyLen,       // Cycles per operation
  output logic [15:0]                dqIn,          // Data to host
  output logic                       readyStatusPin // High when ready
);
  logic [127:0] lockBit = '0;  // No reset input: survives host reset
  logic [15:0]  otp [0:8];
  logic [15:0]  status = 16'h0000;
  logic [15:0]  pend = 16'h0000;
  logic [1:0]   mode = 2'h0;  // Array, status, identification
  logic [7:0]   busy = 8'h00;
  logic [15:0]  rd;
  logic [15:0]  last = 16'h0000;
  logic [7:0]   ofs;
  int           idx;
  logic         blocked;
  logic         lockOk;
  initial begin
    otp[0] = 16'hFFFE;  // Factory segment pre-locked
    for (int i = 1; i < 9; i++) begin
      otp[i] = (i < 5) ? FACTORY_BASE + 16'(i) : 16'hFFFF;
    end
  end
  assign readyStatusPin = (busy == 8'h00);
  assign ofs = pins.addr[8:1];
  always_comb begin
    rd = 16'hFFFF;
    if (mode == 2'h1) begin
      rd = status | {8'h00, readyStatusPin, 7'h00};
    end else if (mode == 2'h2) begin
      if (pins.addr[16:1] == 16'h0002) begin
        rd = {15'h0000, lockBit[pins.addr[23:17]]};
      end else if (pins.addr[23:9] == 15'h0 && ofs >= 8'h80 && ofs <= 8'h88) begin
        rd = otp[ofs - 8'h80];
      end
    end
    // A released bus must not keep showing the last word
    dqIn = (!pins.ceN && !pins.oeN) ? rd : ~last;
  end
  always @(posedge sys_clk) begin
    if (!pins.ceN && !pins.oeN) last <= rd;
    if (busy != 8'h00) busy <= busy - 8'h01;
    if (!pins.ceN && !pins.weN && !pins.dqOe) begin
      if (pend == fsg_pkg::CODE_LOCK_SETUP) begin
        mode <= 2'h1;
        busy <= busyLen;
        pend <= 16'h0000;
        // Lock bits move only with the supply up and no operation still running
        lockOk = progEnable && (busy == 8'h00);
        if (pins.dqOut == fsg_pkg::CODE_LOCK_SET && lockOk) begin
          lockBit[pins.addr[23:17]] <= 1'b1;
        end else if (pins.dqOut == fsg_pkg::CODE_LOCK_CLEAR && lockOk) begin
          lockBit <= '0;
        end else if (pins.dqOut == fsg_pkg::CODE_LOCK_SET) begin
          status <= status | 16'h0010;
        end else begin
          status <= status | 16'h0020;
        end
      end else if (pend == fsg_pkg::CODE_OTP_SETUP) begin
        mode <= 2'h1;
        busy <= busyLen;
        pend <= 16'h0000;
        idx = int'(ofs) - 128;
        blocked = (idx > 0 && idx < 5) ? !otp[0][0] : !otp[0][1];
        if (pins.addr[23:9] != 15'h0 || idx < 0 || idx > 8) begin
          status <= status | 16'h0010;
        end else if (blocked) begin
          status <= status | 16'h0012;
        end else begin
          otp[idx] <= otp[idx] & pins.dqOut;
        end
      end else if (pend == 16'h0040) begin
        // Main array word program: contents are not kept, only the refusals
        mode <= 2'h1;
        busy <= busyLen;
        pend <= 16'h0000;
        if (!progEnable) begin
          status <= status | 16'h0010;
        end else if (lockBit[pins.addr[23:17]]) begin
          status <= status | 16'h0012;
        end
      end else begin
        case (pins.dqOut)
          fsg_pkg::CODE_LOCK_SETUP, fsg_pkg::CODE_OTP_SETUP, 16'h0040: begin
            pend <= pins.dqOut;
            mode <= 2'h1;
          end
          fsg_pkg::CODE_ID_READ: mode <= 2'h2;
          fsg_pkg::CODE_ARRAY_READ: mode <= 2'h0;
          fsg_pkg::CODE_CLEAR_STATUS: status <= 16'h0000;
          default: mode <= 2'h1;
        endcase
      end
    end
  end
endmodule  // fsg_flash_model
`default_nettype wire

/* File: fsg_host_tb.sv */
// Self-checking bench for the flash lock and OTP host controller
`timescale 1ns/100ps
`default_nettype none
module fsg_host_tb;
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  byteMode = 1'b0;
  logic                  cmdValid = 1'b0;
  fsg_pkg::fsg_op_type   cmdOp = fsg_pkg::OP_CLR_STATUS;
  logic [23:0]           cmdAddr = '0;
  logic [15:0]           cmdData = '0;
  logic [7:0]            busyLen = '0;
  logic                  cmdReady, rspValid, readyStatusPin, progEnable;
  logic [15:0]           rspData, dqIn;
  fsg_pkg::fsg_err_type  rspErr;
  fsg_pkg::fsg_pins_type flashPins;
  int                    fails = 0, checks = 0, cycles = 0, blk;
  int                    refLock [128];
  int                    refOtp [9];
  logic [23:0]           badA;
  fsg_host dut (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1), .byteMode(byteMode),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData), .rspErr(rspErr),
    .flashPins(flashPins), .dqIn(dqIn), .readyStatusPin(readyStatusPin),
    .progEnable(progEnable));
  fsg_flash_model flash (.sys_clk(sys_clk), .pins(flashPins), .progEnable(progEnable),
    .busyLen(busyLen), .dqIn(dqIn), .readyStatusPin(readyStatusPin));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic run(input fsg_pkg::fsg_op_type op, input logic [23:0] a, input logic [15:0] v,
                     input logic [15:0] expD, input logic [3:0] expE, input bit cmpD);
    @(posedge sys_clk);
    #1;
    cmdValid = 1'b1;
    cmdOp = op;
    cmdAddr = a;
    cmdData = v;
    busyLen = 8'($urandom_range(0, 12));
    while (cmdReady !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    #1;
    cmdValid = 1'b0;
    cmdAddr = 24'($urandom);  // Request fields are free once taken
    while (rspValid !== 1'b1) @(negedge sys_clk);
    if (cmpD) check(rspData, expD);
    check({12'h000, rspErr}, {12'h000, expE});
  endtask
  task automatic prog(input fsg_pkg::fsg_op_type op, input int i, input logic [15:0] v);
    if ((i > 0 && i < 5) ? (refOtp[0] & 1) == 0 : (refOtp[0] & 2) == 0)
      run(op, 24'h000100 + 24'(2 * i), v, 16'h0092, 4'h5, 1'b1);
    else begin
      refOtp[i] = refOtp[i] & int'(v);
      run(op, 24'h000100 + 24'(2 * i), v, 16'h0080, 4'h0, 1'b1);
    end
  endtask
  task automatic sweep();
    for (int b = 0; b < 128; b++)
      run(fsg_pkg::OP_READ_LOCK, {7'(b), 17'($urandom)}, '0, 16'(refLock[b]), 4'h0,
          1'b1);
    for (int i = 0; i < 9; i++)
      run(fsg_pkg::OP_OTP_READ, 24'h000100 + 24'(2 * i + $urandom_range(0, 1)), '0,
          16'(refOtp[i]), 4'h0, 1'b1);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    // Whole run needs about 3500 cycles
    if (cycles == 60000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(4860));
    foreach (refLock[i]) refLock[i] = 0;
    refOtp[0] = 16'hFFFE;
    for (int i = 1; i < 9; i++) refOtp[i] = (i < 5) ? 16'h5A00 + i : 16'hFFFF;
    repeat (6) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    for (int n = 0; n < 8; n++) begin
      blk = $urandom_range(0, 127);
      run(fsg_pkg::OP_LOCK_BLOCK, {7'(blk), 17'($urandom)}, '0, 16'h0080, 4'h0,
          1'b1);
      refLock[blk] = 1;
    end
    @(posedge sys_clk);
    #1;
    rst = 1'b1;
    @(posedge sys_clk);
    #1;
    rst = 1'b0;
    sweep();
    run(fsg_pkg::OP_UNLOCK_ALL, 24'($urandom), '0, 16'h0080, 4'h0, 1'b1);
    foreach (refLock[i]) refLock[i] = 0;
    for (int k = 0; k < 8; k++) begin
      prog(fsg_pkg::OP_OTP_PROG, $urandom_range(1, 8), 16'($urandom));
    end
    prog(fsg_pkg::OP_OTP_LOCK, 0, 16'hFFFD);
    prog(fsg_pkg::OP_OTP_LOCK, 0, 16'hFFFD);
    for (int k = 5; k < 9; k++) prog(fsg_pkg::OP_OTP_PROG, k, 16'h0000);
    run(fsg_pkg::OP_CLR_STATUS, 24'h000000, '0, '0, 4'h0, 1'b0);
    sweep();
    for (int m = 0; m < 2; m++) begin
      @(posedge sys_clk);
      #1;
      byteMode = m[0];
      for (int i = 0; i < 4; i++) begin
        // Each address misses the OTP window in both bus widths
        case (i)
          0:       badA = 24'h000112;
          1:       badA = 24'h0000FE;
          2:       badA = {4'h0, 4'($urandom_range(1, 15)), 16'h0100};
          default: badA = 24'h000300;
        endcase
        run(fsg_pkg::OP_OTP_READ, badA, '0, 16'h0000, 4'h8, 1'b1);
        run(fsg_pkg::OP_OTP_PROG, badA, 16'($urandom), 16'h0000, 4'h8, 1'b1);
      end
    end
    complete_run();
  end
endmodule  // fsg_host_tb
`default_nettype wire
